// ==== verilog/tcr_timer2.sv ====
// Summary of operation
// R1: capture mode without trigger: plain timer, overflow flag
// R2: trigger fall copies count into reload pair
// R3: up reload: wrap at FFFF sets flag, reloads
// R4: trigger fall also reloads, sets event flag
// R5: up/down: trigger level picks direction
// R6: counting up wraps, flags, reloads from pair
// R7: counting down, match reload: flag, load FFFF
// R8: up/down: event flag is seventeenth bit
// R9: timer with clock output drives 50% clock
// R10: out clock is timer clock / 4(65536-reload)
// R11: clock output mode: overflow raises no interrupt
// R12: run cleared holds count; trigger stays live
// R13: both flags share one interrupt request
// R14: software sets or clears flags; hardware clears only the event flag, by its up/down toggle
// R15: interrupt needs global and timer enables
// R16: down count enable resets to zero
// R17: counter select: timer clock or event pin
// R18: pins synchronised, falls from two samples
`timescale 1ns/1ps
`include "tcr_defines.svh"
module tcr_timer2 (
  input wire logic mclk,
  input wire logic nrst,
  input tcr_pkg::tcr_cfg_type cfg_in,
  input tcr_pkg::tcr_sw_type sw_req,
  input wire logic trigger_pin,
  input wire logic event_clock_pin_i,
  output logic event_clock_pin_o,
  output logic event_clock_pin_oe,
  output logic [15:0] count_q,
  output logic [15:0] reload_q,
  output logic overflow_flag,
  output logic external_event_flag,
  output logic timer_irq
);

  // ========================================================
  // declarations
  // ========================================================
  tcr_pkg::tcr_cfg_type cfg_q;
  tcr_pkg::tcr_mode_type mode;
  logic [3:0] pre_q;
  logic pre_tick;
  logic timer_tick;
  logic tick;
  logic half_q;
  logic count_en;
  logic trig_level;
  logic trig_fall;
  logic ev_fall;
  logic at_top;
  logic at_match;
  logic wrap;
  logic ovf;
  logic ext_evt;
  logic [15:0] count_d;

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ========================================================
  // pin synchronisers
  // ========================================================
  tcr_edge_sync u_trig_sync ( // R18
    .mclk(mclk),
    .nrst(nrst),
    .pin(trigger_pin),
    .level_q(trig_level),
    .fall(trig_fall)
  );

  tcr_edge_sync u_event_sync ( // R18
    .mclk(mclk),
    .nrst(nrst),
    .pin(event_clock_pin_i),
    .level_q(),
    .fall(ev_fall)
  );

  // ========================================================
  // configuration register
  // ========================================================
  // one cycle of latency on every control change
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= `TCR_CFG_RST; // R16
    end else begin
      cfg_q <= cfg_in;
    end
  end

  // ========================================================
  // mode decode
  // ========================================================
  // counter select with clock output is not recommended;
  // it falls back to the counting modes, pin stays input
  always_comb begin
    if (cfg_q.clock_output_enable && !cfg_q.counter_select) begin
      mode = tcr_pkg::TCR_MODE_CLKOUT; // R9
    end else if (cfg_q.capture_not_reload) begin
      mode = tcr_pkg::TCR_MODE_CAPTURE;
    end else if (cfg_q.down_count_enable) begin
      mode = tcr_pkg::TCR_MODE_UPDOWN;
    end else begin
      mode = tcr_pkg::TCR_MODE_RELOAD;
    end
  end

  // ========================================================
  // timer clock prescaler
  // ========================================================
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= 4'h0;
    end else if (pre_tick) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  assign pre_tick = (pre_q == `TCR_PRESCALE_LAST);
  assign timer_tick = cfg_q.prescale_bypass | pre_tick; // R10
  assign tick = cfg_q.counter_select ? ev_fall : timer_tick; // R17

  // clock output mode advances on every second tick, so a
  // full output period spans four timer wraps of half length
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      half_q <= 1'b0;
    end else if (mode != tcr_pkg::TCR_MODE_CLKOUT) begin
      half_q <= 1'b0;
    end else if (cfg_q.run_control && tick) begin
      half_q <= ~half_q; // R10
    end
  end

  // ========================================================
  // count events
  // ========================================================
  assign count_en = cfg_q.run_control & tick & // R12
                    ((mode != tcr_pkg::TCR_MODE_CLKOUT) | half_q);
  assign at_top = (count_q == `TCR_COUNT_TOP);
  assign at_match = (count_q == reload_q);
  assign wrap = count_en & at_top;

  always_comb begin
    case (mode)
      tcr_pkg::TCR_MODE_CAPTURE: begin
        ovf = wrap; // R1
      end
      tcr_pkg::TCR_MODE_RELOAD: begin
        ovf = wrap; // R3
      end
      tcr_pkg::TCR_MODE_UPDOWN: begin
        ovf = count_en & (trig_level ? at_top : at_match); // R5
      end
      tcr_pkg::TCR_MODE_CLKOUT: begin
        ovf = 1'b0; // R11
      end
      default: begin
        ovf = 1'b0;
      end
    endcase
  end

  // trigger enable is ignored while direction comes from the pin
  assign ext_evt = trig_fall & cfg_q.external_trigger_enable & // R5
                   (mode != tcr_pkg::TCR_MODE_UPDOWN);

  // ========================================================
  // counter
  // ========================================================
  always_comb begin
    count_d = count_q;
    case (mode)
      tcr_pkg::TCR_MODE_CAPTURE: begin
        if (count_en) begin
          count_d = count_q + 16'h0001; // R1
        end
      end
      tcr_pkg::TCR_MODE_RELOAD: begin
        if (wrap || ext_evt) begin
          count_d = reload_q; // R3 R4
        end else if (count_en) begin
          count_d = count_q + 16'h0001;
        end
      end
      tcr_pkg::TCR_MODE_UPDOWN: begin
        if (count_en && trig_level) begin
          count_d = at_top ? reload_q : count_q + 16'h0001; // R6
        end else if (count_en) begin
          count_d = at_match ? `TCR_COUNT_TOP : count_q - 16'h0001; // R7
        end
      end
      tcr_pkg::TCR_MODE_CLKOUT: begin
        if (wrap || ext_evt) begin
          count_d = reload_q; // R10
        end else if (count_en) begin
          count_d = count_q + 16'h0001;
        end
      end
      default: begin
        count_d = count_q;
      end
    endcase
  end

  // software write takes priority over counting
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_q <= `TCR_COUNT_RST;
    end else if (sw_req.count_wr) begin
      count_q <= sw_req.count_data;
    end else begin
      count_q <= count_d;
    end
  end

  // ========================================================
  // reload / capture pair
  // ========================================================
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reload_q <= `TCR_RELOAD_RST;
    end else if (sw_req.reload_wr) begin
      reload_q <= sw_req.reload_data;
    end else if (ext_evt && mode == tcr_pkg::TCR_MODE_CAPTURE) begin
      reload_q <= count_q; // R2
    end
  end

  // ========================================================
  // flags; a hardware set beats a software clear
  // ========================================================
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag <= 1'b0;
    end else if (ovf || sw_req.set_overflow) begin
      overflow_flag <= 1'b1; // R14
    end else if (sw_req.clr_overflow) begin
      overflow_flag <= 1'b0; // R14
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      external_event_flag <= 1'b0;
    end else if (sw_req.set_event) begin
      external_event_flag <= 1'b1; // R14
    end else if (mode == tcr_pkg::TCR_MODE_UPDOWN && ovf) begin
      external_event_flag <= ~external_event_flag; // R8
    end else if (ext_evt) begin
      external_event_flag <= 1'b1; // R2 R4
    end else if (sw_req.clr_event) begin
      external_event_flag <= 1'b0; // R14
    end
  end

  // ========================================================
  // interrupt request
  // ========================================================
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= cfg_q.global_irq_enable & cfg_q.timer_irq_enable & // R15
                   (overflow_flag | // R13
                    (external_event_flag & (mode != tcr_pkg::TCR_MODE_UPDOWN))); // R8
    end
  end

  // ========================================================
  // clock output
  // ========================================================
  // toggle on each wrap; output rests low outside the mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      event_clock_pin_o <= 1'b0;
    end else if (mode != tcr_pkg::TCR_MODE_CLKOUT) begin
      event_clock_pin_o <= 1'b0;
    end else if (wrap) begin
      event_clock_pin_o <= ~event_clock_pin_o; // R9 R10
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      event_clock_pin_oe <= 1'b0;
    end else begin
      event_clock_pin_oe <= (mode == tcr_pkg::TCR_MODE_CLKOUT); // R11
    end
  end

  // ========================================================
  // assertions
  // ========================================================
  a_reload_wrap: // R3
  assert property (mode == tcr_pkg::TCR_MODE_RELOAD && wrap && !sw_req.count_wr
                   |=> overflow_flag && count_q == $past(reload_q))
    else $error("reload wrap did not flag and reload");

  a_capture_copy: // R2
  assert property (mode == tcr_pkg::TCR_MODE_CAPTURE && ext_evt && !sw_req.reload_wr
                   |=> reload_q == $past(count_q) && external_event_flag)
    else $error("capture did not copy count");

  a_trigger_reload: // R4
  assert property (mode == tcr_pkg::TCR_MODE_RELOAD && ext_evt && !sw_req.count_wr
                   |=> count_q == $past(reload_q) && external_event_flag)
    else $error("trigger did not reload");

  a_stop_hold: // R12
  assert property (!cfg_q.run_control && !sw_req.count_wr && !ext_evt
                   |=> count_q == $past(count_q))
    else $error("count moved while stopped");

  a_down_match: // R7
  assert property (mode == tcr_pkg::TCR_MODE_UPDOWN && count_en && !trig_level
                   && at_match && !sw_req.count_wr
                   |=> count_q == `TCR_COUNT_TOP && overflow_flag)
    else $error("down match did not load top");

  a_up_wrap: // R6
  assert property (mode == tcr_pkg::TCR_MODE_UPDOWN && wrap && trig_level
                   && !sw_req.count_wr
                   |=> count_q == $past(reload_q) && overflow_flag)
    else $error("up wrap did not reload");

  a_event_bit: // R8
  assert property (mode == tcr_pkg::TCR_MODE_UPDOWN && !overflow_flag
                   |=> !timer_irq)
    else $error("event flag requested interrupt in up/down");

  a_flag_sticky: // R14
  assert property (overflow_flag && !sw_req.clr_overflow |=> overflow_flag)
    else $error("overflow flag cleared by hardware");

  a_irq_gate: // R15
  assert property (cfg_q.global_irq_enable && cfg_q.timer_irq_enable && overflow_flag
                   |=> timer_irq)
    else $error("enabled overflow gave no interrupt");

  a_irq_off: // R15
  assert property (!cfg_q.global_irq_enable || !cfg_q.timer_irq_enable |=> !timer_irq)
    else $error("interrupt with enables off");

  a_clkout_quiet: // R11
  assert property (mode == tcr_pkg::TCR_MODE_CLKOUT && !overflow_flag
                   && !sw_req.set_overflow |=> !overflow_flag)
    else $error("overflow flag set in clock output mode");

  a_clkout_toggle: // R9
  assert property (mode == tcr_pkg::TCR_MODE_CLKOUT && wrap
                   |=> event_clock_pin_o != $past(event_clock_pin_o) && event_clock_pin_oe)
    else $error("clock output did not toggle on wrap");

  a_plain_ovf: // R1
  assert property (mode == tcr_pkg::TCR_MODE_CAPTURE && wrap && !sw_req.count_wr
                   |=> count_q == 16'h0000 && overflow_flag)
    else $error("capture mode wrap wrong");

  c_capture: cover property (mode == tcr_pkg::TCR_MODE_CAPTURE && ext_evt);
  c_down_match: cover property (mode == tcr_pkg::TCR_MODE_UPDOWN && ovf && !trig_level);
  c_clk_toggle: cover property (mode == tcr_pkg::TCR_MODE_CLKOUT && wrap);
  c_irq: cover property (timer_irq);

endmodule

// ==== verilog/tcr_defines.svh ====
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

// ==========================================================
// timing
// ==========================================================
// timer clock is fsys divided by twelve unless bypassed
`define TCR_PRESCALE_DIV 4'hC
`define TCR_PRESCALE_LAST 4'hB

// ==========================================================
// count limits and reset values
// ==========================================================
`define TCR_COUNT_TOP 16'hFFFF
`define TCR_COUNT_RST 16'h0000
`define TCR_RELOAD_RST 16'h0000
`define TCR_CFG_RST 9'h000

// ==========================================================
// configuration field positions
// ==========================================================
`define TCR_CFG_RUN 8
`define TCR_CFG_CNTSEL 7
`define TCR_CFG_CAPTURE 6
`define TCR_CFG_EXTEN 5
`define TCR_CFG_CLKOE 4
`define TCR_CFG_DOWN_COUNT_ENABLE 3
`define TCR_CFG_BYPASS 2
`define TCR_CFG_TIE 1
`define TCR_CFG_GIE 0

`endif

// ==== verilog/tcr_pkg.sv ====
package tcr_pkg;

  // ========================================================
  // configuration bits, held as a register inside the block
  // ========================================================
  typedef struct packed {
    logic run_control;
    logic counter_select;
    logic capture_not_reload;
    logic external_trigger_enable;
    logic clock_output_enable;
    logic down_count_enable;
    logic prescale_bypass;
    logic timer_irq_enable;
    logic global_irq_enable;
  } tcr_cfg_type;

  // ========================================================
  // software writes, one-cycle strobes with data
  // ========================================================
  typedef struct packed {
    logic count_wr;
    logic [15:0] count_data;
    logic reload_wr;
    logic [15:0] reload_data;
    logic set_overflow;
    logic clr_overflow;
    logic set_event;
    logic clr_event;
  } tcr_sw_type;

  // ========================================================
  // operating modes
  // ========================================================
  typedef enum logic [1:0] {
    TCR_MODE_CAPTURE,
    TCR_MODE_RELOAD,
    TCR_MODE_UPDOWN,
    TCR_MODE_CLKOUT
  } tcr_mode_type;

endpackage

// ==== verilog/tcr_edge_sync.sv ====
`timescale 1ns/1ps
module tcr_edge_sync (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pin,
  output logic level_q,
  output logic fall
);

  logic meta_q;
  logic last_q;

  // ========================================================
  // two-stage synchroniser, then edge history
  // ========================================================
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      level_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin;
      level_q <= meta_q;
      last_q <= level_q;
    end
  end

  // only synchronised samples feed the edge compare
  assign fall = last_q & ~level_q;

endmodule

// ==== dv/tcr_pin_model.sv ====
`timescale 1ns/1ps
module tcr_pin_model (
  input wire logic mclk,
  input wire logic trig_lvl,
  input wire logic evt_lvl,
  input wire logic evt_out,
  input wire logic evt_oe,
  input wire logic timer_irq,
  output logic trigger_pin,
  output logic event_wire,
  output int irq_seen
);
  logic irq_q = 1'b0;
  // ========================================================
  // pins
  // ========================================================
  // trigger line has a pull-up, so idle is high
  assign trigger_pin = trig_lvl;
  // shared event line: block drives it only in clock output mode
  assign event_wire = evt_oe ? evt_out : evt_lvl;
  // ========================================================
  // cpu interrupt side
  // ========================================================
  // counts rising requests, one vector for both flags
  initial irq_seen = 0;
  always @(posedge mclk) begin
    if (timer_irq === 1'b1 && irq_q === 1'b0) begin
      irq_seen <= irq_seen + 1;
    end
    irq_q <= timer_irq;
  end
endmodule

// ==== dv/test_tcr_timer2.sv ====
`timescale 1ns/1ps
module test_tcr_timer2;
  // ========================================================
  // signals
  // ========================================================
  typedef struct {
    logic [8:0] cfg;
    logic [15:0] cnt;
    logic [15:0] rel;
    logic trig;
    int cyc;
    logic [15:0] exp;
    logic ovf;
    logic evt;
  } tcr_row_type;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  tcr_pkg::tcr_cfg_type cfg = '0;
  tcr_pkg::tcr_sw_type sw = '0;
  logic trig_lvl = 1'b1;
  logic evt_lvl = 1'b1;
  logic trigger_pin, event_wire, evt_out, evt_oe, ovf, evt, irq;
  logic [15:0] count, reload;
  int irq_seen;
  int fails = 0;
  int checked = 0;
  int n;
  tcr_row_type rows [7] = '{
    '{9'h144, 16'hFFFE, 16'h0000, 1'b1, 3, 16'h0001, 1'b1, 1'b0},
    '{9'h104, 16'hFFFE, 16'h1234, 1'b1, 3, 16'h1235, 1'b1, 1'b0},
    '{9'h10C, 16'hFFFE, 16'h1234, 1'b1, 3, 16'h1235, 1'b1, 1'b1},
    '{9'h10C, 16'h1236, 16'h1234, 1'b0, 4, 16'hFFFE, 1'b1, 1'b1},
    '{9'h004, 16'h5555, 16'h0000, 1'b1, 5, 16'h5555, 1'b0, 1'b0},
    '{9'h100, 16'hFFF0, 16'h0000, 1'b1, 24, 16'hFFF2, 1'b0, 1'b0},
    '{9'h184, 16'h0010, 16'h0000, 1'b1, 6, 16'h0010, 1'b0, 1'b0}
  };

  always #5 mclk = ~mclk;

  tcr_timer2 dut (
    .mclk(mclk),
    .nrst(nrst),
    .cfg_in(cfg),
    .sw_req(sw),
    .trigger_pin(trigger_pin),
    .event_clock_pin_i(event_wire),
    .event_clock_pin_o(evt_out),
    .event_clock_pin_oe(evt_oe),
    .count_q(count),
    .reload_q(reload),
    .overflow_flag(ovf),
    .external_event_flag(evt),
    .timer_irq(irq)
  );

  tcr_pin_model pins (
    .mclk(mclk),
    .trig_lvl(trig_lvl),
    .evt_lvl(evt_lvl),
    .evt_out(evt_out),
    .evt_oe(evt_oe),
    .timer_irq(irq),
    .trigger_pin(trigger_pin),
    .event_wire(event_wire),
    .irq_seen(irq_seen)
  );

  // ========================================================
  // tasks
  // ========================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input tcr_pkg::tcr_sw_type s);
    @(negedge mclk);
    sw = s;
    @(negedge mclk);
    sw = '0;
  endtask

  // loads both words and clears both flags in one strobe
  task automatic load(input logic [15:0] c, input logic [15:0] r);
    tcr_pkg::tcr_sw_type s;
    s = '0;
    s.count_wr = 1'b1;
    s.count_data = c;
    s.reload_wr = 1'b1;
    s.reload_data = r;
    s.clr_overflow = 1'b1;
    s.clr_event = 1'b1;
    pulse(s);
  endtask

  // f is set_ovf, clr_ovf, set_evt, clr_evt
  task automatic flags(input logic [3:0] f);
    tcr_pkg::tcr_sw_type s;
    s = '0;
    {s.set_overflow, s.clr_overflow, s.set_event, s.clr_event} = f;
    pulse(s);
  endtask

  // bounded: a stuck pin ends at 40 and fails its compare
  task automatic run_len(input logic lvl, output int len);
    for (len = 0; len < 40 && evt_out === lvl; len++) @(negedge mclk);
  endtask

  task automatic stop_test;
    $display("Checks %0d, errors %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ========================================================
  // sequence
  // ========================================================
  initial begin
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    chk(count, 16'h0000);
    chk({ovf, evt, irq, evt_oe}, 16'h0000);
    foreach (rows[i]) begin
      cfg = tcr_pkg::tcr_cfg_type'(rows[i].cfg & 9'h0FF);
      trig_lvl = rows[i].trig;
      load(rows[i].cnt, rows[i].rel);
      repeat (4) @(negedge mclk);
      cfg = tcr_pkg::tcr_cfg_type'(rows[i].cfg);
      repeat (rows[i].cyc) @(negedge mclk);
      cfg.run_control = 1'b0;
      @(negedge mclk);
      chk(count, rows[i].exp);
      chk({ovf, evt}, {rows[i].ovf, rows[i].evt});
    end
    // capture while stopped: trigger path stays live
    cfg = tcr_pkg::tcr_cfg_type'(9'h063);
    load(16'hABCD, 16'h0000);
    trig_lvl = 1'b0;
    repeat (6) @(negedge mclk);
    trig_lvl = 1'b1;
    chk(reload, 16'hABCD);
    chk(count, 16'hABCD);
    chk({evt, irq}, 2'b11);
    chk(irq_seen[15:0], 16'h0001);
    cfg.global_irq_enable = 1'b0;
    flags(4'h9);
    repeat (3) @(negedge mclk);
    chk({ovf, evt, irq}, 3'b100);
    cfg.global_irq_enable = 1'b1;
    repeat (3) @(negedge mclk);
    chk(irq, 1'b1);
    // reload from trigger fall, count frozen otherwise
    cfg = tcr_pkg::tcr_cfg_type'(9'h020);
    load(16'h0100, 16'h4000);
    trig_lvl = 1'b0;
    repeat (6) @(negedge mclk);
    trig_lvl = 1'b1;
    chk(count, 16'h4000);
    chk(evt, 1'b1);
    // up/down ignores trigger enable; event flag raises no request
    cfg = tcr_pkg::tcr_cfg_type'(9'h02B);
    load(16'h0100, 16'h4000);
    trig_lvl = 1'b0;
    repeat (6) @(negedge mclk);
    trig_lvl = 1'b1;
    flags(4'h2);
    repeat (3) @(negedge mclk);
    chk(count, 16'h0100);
    chk({ovf, evt, irq}, 3'b010);
    // event pin counting, pulses well above the sync limit
    cfg = tcr_pkg::tcr_cfg_type'(9'h084);
    load(16'h0000, 16'h0000);
    cfg = tcr_pkg::tcr_cfg_type'(9'h184);
    for (n = 0; n < 3; n++) begin
      evt_lvl = 1'b0;
      repeat (4) @(negedge mclk);
      evt_lvl = 1'b1;
      repeat (4) @(negedge mclk);
    end
    cfg = tcr_pkg::tcr_cfg_type'(9'h084);
    repeat (2) @(negedge mclk);
    chk(count, 16'h0003);
    // clock output: reload FFFE gives 4 high, 4 low
    cfg = tcr_pkg::tcr_cfg_type'(9'h017);
    load(16'hFFFE, 16'hFFFE);
    cfg = tcr_pkg::tcr_cfg_type'(9'h117);
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk(n[15:0], 16'h0004);
    run_len(1'b0, n);
    chk(n[15:0], 16'h0004);
    chk({evt_oe, ovf, irq}, 3'b100);
    // second reload value: FFFC gives 8 low; first run may be partial
    cfg = tcr_pkg::tcr_cfg_type'(9'h017);
    load(16'hFFFC, 16'hFFFC);
    cfg = tcr_pkg::tcr_cfg_type'(9'h117);
    run_len(1'b0, n);
    run_len(1'b1, n);
    run_len(1'b0, n);
    chk(n[15:0], 16'h0008);
    // reset in mid-run clears flags, count and pin drive
    flags(4'hA);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    chk({ovf, evt, irq, evt_oe, evt_out}, 16'h0000);
    chk(count, 16'h0000);
    cfg = '0;
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
    chk({ovf, evt, irq, evt_oe, evt_out}, 16'h0000);
    chk(reload, 16'h0000);
    stop_test();
  end
endmodule
